// File: rtl/scfc_params.svh
// Purpose: Constants for the serial channel framing and configuration block
// Assumes: 40 MHz clock; codes below are the values seen on the config ports
// Notes: Each figure is named once here and used by name in the logic
//
// What this block does
// - Set-channel command updates channel operating parameters
// - No operands: prompt each parameter with current value
// - Bare return keeps value; new value replaces it
// - Handshake: one-character hardware or software flow
// - Baud 19200 down to 300 selectable
// - Character length 7 or 8 bits
// - Parity none, even or odd; generated, checked
// - Stop length one or two bits
// - Defaults: char handshake, 9600, 8 bits, none, two
// - Both ends share baud, parity, stop length
// - Channel acts in modem role toward partner
// - Partner setup: 8 bits, two stops, hardware handshake
`ifndef SCFC_PARAMS_SVH
`define SCFC_PARAMS_SVH
`define SCFC_CLK_HZ 40000000
`define SCFC_RATE_19200 19200
`define SCFC_RATE_9600 9600
`define SCFC_RATE_4800 4800
`define SCFC_RATE_2400 2400
`define SCFC_RATE_1200 1200
`define SCFC_RATE_600 600
`define SCFC_RATE_300 300
`define SCFC_BAUD_19200 3'h0
`define SCFC_BAUD_9600 3'h1
`define SCFC_BAUD_4800 3'h2
`define SCFC_BAUD_2400 3'h3
`define SCFC_BAUD_1200 3'h4
`define SCFC_BAUD_600 3'h5
`define SCFC_BAUD_300 3'h6
`define SCFC_PAR_NONE 2'h0
`define SCFC_PAR_EVEN 2'h1
`define SCFC_PAR_ODD 2'h2
`define SCFC_FLD_MODE 3'h0
`define SCFC_FLD_BAUD 3'h1
`define SCFC_FLD_LONG 3'h2
`define SCFC_FLD_PAR 3'h3
`define SCFC_FLD_STOP 3'h4
`define SCFC_OP_MODE 0
`define SCFC_OP_BAUD 1
`define SCFC_OP_LONG 2
`define SCFC_OP_PAR 3
`define SCFC_OP_STOP 4
`define SCFC_RST_FLOW 1'h0
`define SCFC_RST_BAUD `SCFC_BAUD_9600
`define SCFC_RST_LONG8 1'h1
`define SCFC_RST_PAR `SCFC_PAR_NONE
`define SCFC_RST_STOP2 1'h1
`define SCFC_XON 8'h11
`define SCFC_XOFF 8'h13
`define SCFC_LAST7 3'h6
`define SCFC_LAST8 3'h7
`endif

// File: rtl/scfc_pkg.sv
// Purpose: Types for the serial channel framing and configuration block
// Assumes: Used with scfc_params.svh
// Notes: State enums only; codes are left to the tools
package scfc_pkg;
    typedef enum logic [2:0] {
        scfc_cfg_idle, scfc_cfg_mode, scfc_cfg_baud, scfc_cfg_long, scfc_cfg_par, scfc_cfg_stop
    } scfc_cfg_st_t;
    typedef enum logic [2:0] {
        scfc_ln_idle, scfc_ln_start, scfc_ln_data, scfc_ln_par, scfc_ln_stop
    } scfc_ln_st_t;
endpackage

// File: rtl/scfc_channel.sv
// Purpose: Serial channel with command and prompt driven framing setup
// Assumes: All inputs synchronous to clk; ce low freezes all state
// Notes: Modem role; in character handshake cts_out paces the partner one character at a time
`timescale 1ns/1ps
`default_nettype none
`include "scfc_params.svh"
module scfc_channel
    import scfc_pkg::*;
#(
    parameter int CLK_HZ = `SCFC_CLK_HZ
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Set-channel command with operands
    input wire logic set_channel_command,
    input wire logic [4:0] cmd_present,
    input wire logic op_flow,
    input wire logic [2:0] op_baud,
    input wire logic op_long8,
    input wire logic [1:0] parity_operand,
    input wire logic op_stop2,
    // Interactive prompt and answer
    output logic prompt_valid,
    output logic [2:0] prompt_field,
    output logic [2:0] prompt_value,
    input wire logic answer_valid,
    input wire logic answer_keep,
    input wire logic [2:0] answer_value,
    // Current settings
    output logic cfg_flow,
    output logic [2:0] cfg_baud,
    output logic cfg_long8,
    output logic [1:0] cfg_parity,
    output logic cfg_stop2,
    // Transmit stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Receive stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_parity_err,
    output logic rx_frame_err,
    input wire logic rx_ack,
    // Line, modem role
    output logic ser_out,
    input wire logic ser_in,
    input wire logic rts_in,
    output logic cts_out,
    output logic dsr_out,
    output logic dcd_out
);
    function automatic logic [17:0] bit_div(input logic [2:0] sel);
        unique case (sel)
            `SCFC_BAUD_19200: bit_div = 18'(CLK_HZ / `SCFC_RATE_19200);
            `SCFC_BAUD_9600: bit_div = 18'(CLK_HZ / `SCFC_RATE_9600);
            `SCFC_BAUD_4800: bit_div = 18'(CLK_HZ / `SCFC_RATE_4800);
            `SCFC_BAUD_2400: bit_div = 18'(CLK_HZ / `SCFC_RATE_2400);
            `SCFC_BAUD_1200: bit_div = 18'(CLK_HZ / `SCFC_RATE_1200);
            `SCFC_BAUD_600: bit_div = 18'(CLK_HZ / `SCFC_RATE_600);
            default: bit_div = 18'(CLK_HZ / `SCFC_RATE_300);
        endcase
    endfunction

    function automatic logic par_bit(input logic [7:0] d, input logic l8, input logic [1:0] p);
        par_bit = ((l8 ? ^d : ^d[6:0]) ^ (p == `SCFC_PAR_ODD));
    endfunction

    // Configuration and prompting
    scfc_cfg_st_t cst_q, cst_d;
    logic flow_q, flow_d, l8_q, l8_d, s2_q, s2_d;
    logic [2:0] baud_q, baud_d;
    logic [1:0] par_q, par_d;

    always_comb begin
        cst_d = cst_q;
        flow_d = flow_q;
        baud_d = baud_q;
        l8_d = l8_q;
        par_d = par_q;
        s2_d = s2_q;
        if (cst_q == scfc_cfg_idle && set_channel_command) begin
            if (cmd_present == 5'h00) begin
                cst_d = scfc_cfg_mode;
            end else begin
                if (cmd_present[`SCFC_OP_MODE]) flow_d = op_flow;
                if (cmd_present[`SCFC_OP_BAUD]) baud_d = op_baud;
                if (cmd_present[`SCFC_OP_LONG]) l8_d = op_long8;
                if (cmd_present[`SCFC_OP_PAR]) par_d = parity_operand;
                if (cmd_present[`SCFC_OP_STOP]) s2_d = op_stop2;
            end
        end else if (cst_q != scfc_cfg_idle && answer_valid) begin
            unique case (cst_q)
                scfc_cfg_mode: begin
                    if (!answer_keep) flow_d = answer_value[0];
                    cst_d = scfc_cfg_baud;
                end
                scfc_cfg_baud: begin
                    if (!answer_keep) baud_d = answer_value;
                    cst_d = scfc_cfg_long;
                end
                scfc_cfg_long: begin
                    if (!answer_keep) l8_d = answer_value[0];
                    cst_d = scfc_cfg_par;
                end
                scfc_cfg_par: begin
                    if (!answer_keep) par_d = answer_value[1:0];
                    cst_d = scfc_cfg_stop;
                end
                scfc_cfg_stop: begin
                    if (!answer_keep) s2_d = answer_value[0];
                    cst_d = scfc_cfg_idle;
                end
                default: cst_d = scfc_cfg_idle;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cst_q <= scfc_cfg_idle;
            flow_q <= `SCFC_RST_FLOW;
            baud_q <= `SCFC_RST_BAUD;
            l8_q <= `SCFC_RST_LONG8;
            par_q <= `SCFC_RST_PAR;
            s2_q <= `SCFC_RST_STOP2;
        end else if (ce) begin
            cst_q <= cst_d;
            flow_q <= flow_d;
            baud_q <= baud_d;
            l8_q <= l8_d;
            par_q <= par_d;
            s2_q <= s2_d;
        end
    end

    always_comb begin
        prompt_valid = (cst_q != scfc_cfg_idle);
        prompt_field = `SCFC_FLD_MODE;
        prompt_value = {2'h0, flow_q};
        unique case (cst_q)
            scfc_cfg_baud: begin
                prompt_field = `SCFC_FLD_BAUD;
                prompt_value = baud_q;
            end
            scfc_cfg_long: begin
                prompt_field = `SCFC_FLD_LONG;
                prompt_value = {2'h0, l8_q};
            end
            scfc_cfg_par: begin
                prompt_field = `SCFC_FLD_PAR;
                prompt_value = {1'h0, par_q};
            end
            scfc_cfg_stop: begin
                prompt_field = `SCFC_FLD_STOP;
                prompt_value = {2'h0, s2_q};
            end
            default: ;
        endcase
    end

    assign cfg_flow = flow_q;
    assign cfg_baud = baud_q;
    assign cfg_long8 = l8_q;
    assign cfg_parity = par_q;
    assign cfg_stop2 = s2_q;

    // Transmitter
    scfc_ln_st_t tst_q, tst_d;
    logic [17:0] tcnt_q, tcnt_d;
    logic [2:0] tbit_q, tbit_d;
    logic [7:0] tsh_q, tsh_d;
    logic tstop_q, tstop_d, tout_q, tout_d, paused_q, paused_d;
    logic tgo, ttick, rx_done;
    logic [7:0] rsh_q;

    assign tgo = flow_q ? !paused_q : rts_in;
    assign tx_ready = (tst_q == scfc_ln_idle) && tgo;
    assign ttick = (tcnt_q == 18'h00000);

    always_comb begin
        tst_d = tst_q;
        tcnt_d = ttick ? 18'h00000 : tcnt_q - 18'h00001;
        tbit_d = tbit_q;
        tsh_d = tsh_q;
        tstop_d = tstop_q;
        tout_d = tout_q;
        paused_d = paused_q;
        if (rx_done && flow_q && rsh_q == `SCFC_XOFF) paused_d = 1'h1;
        if (rx_done && flow_q && rsh_q == `SCFC_XON) paused_d = 1'h0;
        if (!flow_q) paused_d = 1'h0;
        unique case (tst_q)
            scfc_ln_idle: begin
                tout_d = 1'h1;
                if (tx_valid && tx_ready) begin
                    tsh_d = tx_data;
                    tout_d = 1'h0;
                    tcnt_d = bit_div(baud_q) - 18'h00001;
                    tst_d = scfc_ln_start;
                end
            end
            scfc_ln_start: if (ttick) begin
                tout_d = tsh_q[0];
                tbit_d = 3'h0;
                tcnt_d = bit_div(baud_q) - 18'h00001;
                tst_d = scfc_ln_data;
            end
            scfc_ln_data: if (ttick) begin
                tcnt_d = bit_div(baud_q) - 18'h00001;
                if (tbit_q == (l8_q ? `SCFC_LAST8 : `SCFC_LAST7)) begin
                    tstop_d = s2_q;
                    if (par_q == `SCFC_PAR_NONE) begin
                        tout_d = 1'h1;
                        tst_d = scfc_ln_stop;
                    end else begin
                        tout_d = par_bit(tsh_q, l8_q, par_q);
                        tst_d = scfc_ln_par;
                    end
                end else begin
                    tbit_d = tbit_q + 3'h1;
                    tout_d = tsh_q[tbit_q + 3'h1];
                end
            end
            scfc_ln_par: if (ttick) begin
                tcnt_d = bit_div(baud_q) - 18'h00001;
                tout_d = 1'h1;
                tst_d = scfc_ln_stop;
            end
            scfc_ln_stop: if (ttick) begin
                if (tstop_q) begin
                    tstop_d = 1'h0;
                    tcnt_d = bit_div(baud_q) - 18'h00001;
                end else begin
                    tst_d = scfc_ln_idle;
                end
            end
            default: tst_d = scfc_ln_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tst_q <= scfc_ln_idle;
            tcnt_q <= 18'h00000;
            tbit_q <= 3'h0;
            tsh_q <= 8'h00;
            tstop_q <= 1'h0;
            tout_q <= 1'h1;
            paused_q <= 1'h0;
        end else if (ce) begin
            tst_q <= tst_d;
            tcnt_q <= tcnt_d;
            tbit_q <= tbit_d;
            tsh_q <= tsh_d;
            tstop_q <= tstop_d;
            tout_q <= tout_d;
            paused_q <= paused_d;
        end
    end

    assign ser_out = tout_q;

    // Receiver, samples at mid-bit
    scfc_ln_st_t rst_q, rst_d;
    logic [17:0] rcnt_q, rcnt_d;
    logic [2:0] rbit_q, rbit_d;
    logic [7:0] rsh_d, rdat_q, rdat_d;
    logic rperr_q, rperr_d, rferr_q, rferr_d, rval_q, rval_d, rpar_q, rpar_d;
    logic rtick;

    assign rtick = (rcnt_q == 18'h00000);
    assign rx_done = (rst_q == scfc_ln_stop) && rtick;

    always_comb begin
        rst_d = rst_q;
        rcnt_d = rtick ? 18'h00000 : rcnt_q - 18'h00001;
        rbit_d = rbit_q;
        rsh_d = rsh_q;
        rdat_d = rdat_q;
        rperr_d = rperr_q;
        rferr_d = rferr_q;
        rpar_d = rpar_q;
        rval_d = rval_q && !rx_ack;
        unique case (rst_q)
            scfc_ln_idle: if (!ser_in) begin
                rcnt_d = (bit_div(baud_q) >> 1) - 18'h00001;
                rst_d = scfc_ln_start;
            end
            scfc_ln_start: if (rtick) begin
                rcnt_d = bit_div(baud_q) - 18'h00001;
                rbit_d = 3'h0;
                rsh_d = 8'h00;
                rst_d = ser_in ? scfc_ln_idle : scfc_ln_data;
            end
            scfc_ln_data: if (rtick) begin
                rcnt_d = bit_div(baud_q) - 18'h00001;
                rsh_d[rbit_q] = ser_in;
                rbit_d = rbit_q + 3'h1;
                if (rbit_q == (l8_q ? `SCFC_LAST8 : `SCFC_LAST7)) begin
                    rst_d = (par_q == `SCFC_PAR_NONE) ? scfc_ln_stop : scfc_ln_par;
                end
            end
            scfc_ln_par: if (rtick) begin
                rcnt_d = bit_div(baud_q) - 18'h00001;
                rpar_d = (ser_in != par_bit(rsh_q, l8_q, par_q));
                rst_d = scfc_ln_stop;
            end
            scfc_ln_stop: if (rtick) begin
                rdat_d = rsh_q;
                rperr_d = (par_q != `SCFC_PAR_NONE) && rpar_q;
                rferr_d = !ser_in;
                rval_d = 1'h1;
                rpar_d = 1'h0;
                rst_d = scfc_ln_idle;
            end
            default: rst_d = scfc_ln_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_q <= scfc_ln_idle;
            rcnt_q <= 18'h00000;
            rbit_q <= 3'h0;
            rsh_q <= 8'h00;
            rdat_q <= 8'h00;
            rperr_q <= 1'h0;
            rferr_q <= 1'h0;
            rpar_q <= 1'h0;
            rval_q <= 1'h0;
        end else if (ce) begin
            rst_q <= rst_d;
            rcnt_q <= rcnt_d;
            rbit_q <= rbit_d;
            rsh_q <= rsh_d;
            rdat_q <= rdat_d;
            rperr_q <= rperr_d;
            rferr_q <= rferr_d;
            rpar_q <= rpar_d;
            rval_q <= rval_d;
        end
    end

    assign rx_valid = rval_q;
    assign rx_data = rdat_q;
    assign rx_parity_err = rperr_q;
    assign rx_frame_err = rferr_q;
    assign cts_out = flow_q || !rval_q;
    assign dsr_out = 1'h1;
    assign dcd_out = 1'h1;

    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);

    cmd_apply_a: assert property (ce && cst_q == scfc_cfg_idle && set_channel_command
        && cmd_present[`SCFC_OP_BAUD] |=> cfg_baud == $past(op_baud)) else $error("baud not set");
    prompt_start_a: assert property (ce && cst_q == scfc_cfg_idle && set_channel_command
        && cmd_present == 5'h00 |=> prompt_valid && prompt_field == `SCFC_FLD_MODE)
        else $error("no prompt");
    keep_value_a: assert property (ce && prompt_valid && answer_valid && answer_keep
        |=> $stable({flow_q, baud_q, l8_q, par_q, s2_q})) else $error("kept value changed");
    reset_dflt_a: assert property ($past(sys_rst) |-> !cfg_flow && cfg_baud == `SCFC_BAUD_9600
        && cfg_long8 && cfg_parity == `SCFC_PAR_NONE && cfg_stop2) else $error("bad defaults");
    xoff_pause_a: assert property (ce && cfg_flow && rx_done && rsh_q == `SCFC_XOFF
        |=> !tx_ready) else $error("sent after xoff");
    char_hs_a: assert property (ce && !cfg_flow && rx_done |=> !cts_out)
        else $error("cts while full");
    start_low_a: assert property (tst_q == scfc_ln_start |-> !ser_out) else $error("start high");
    stop_high_a: assert property (tst_q == scfc_ln_stop |-> ser_out) else $error("stop low");
    no_parity_a: assert property (cfg_parity == `SCFC_PAR_NONE && tst_q == scfc_ln_data
        && $stable(cfg_parity) |=> tst_q != scfc_ln_par) else $error("parity sent");
    short_len_a: assert property (!cfg_long8 && tst_q == scfc_ln_data
        |-> tbit_q <= `SCFC_LAST7) else $error("too many bits");
    rate_cnt_a: assert property (tst_q != scfc_ln_idle |-> tcnt_q < bit_div(cfg_baud))
        else $error("bit timer too long");
    two_stop_a: assert property (ce && tst_q == scfc_ln_data && tst_d == scfc_ln_stop
        |=> tstop_q == cfg_stop2) else $error("stop count");

    cover property (tst_q == scfc_ln_stop && ttick && ce);
    cover property (rx_valid && rx_parity_err);
    cover property (prompt_valid && prompt_field == `SCFC_FLD_STOP && answer_valid);
    cover property (cfg_flow && paused_q);
endmodule
`default_nettype wire

// File: tb/scfc_partner.sv
// Purpose: Switch-configured programmer end of the serial link
// Assumes: insp and the rate switches are read when a character starts, the parity and stop switches as those bits go out; always 8 data bits
// Notes: Only the sending side is modelled; the bench checks ser_out itself
`timescale 1ns/1ps
`default_nettype none
module scfc_partner #(
    parameter int CLK_HZ = 160000
) (
    // Clock and switch banks
    input wire logic clk,
    input wire logic [7:0] sw,
    input wire logic [3:0] insp,
    // Flow control and line
    input wire logic busy,
    input wire logic cts,
    output logic ser,
    output logic rts
);
    assign rts = !busy;
    initial ser = 1'b1;
    function automatic int rate(input logic [2:0] s);
        case (s)
            3'h0: rate = 110;
            3'h1: rate = 300;
            3'h2: rate = 600;
            3'h3: rate = 1200;
            3'h4: rate = 2400;
            3'h5: rate = 4800;
            default: rate = 9600;
        endcase
    endfunction
    task automatic bit_out(input logic b, input int n);
        ser = b;
        repeat (n) @(negedge clk);
    endtask
    task automatic send(input logic [7:0] c);
        int k = 0;
        int t = CLK_HZ / rate(sw[2:0]);
        if (insp !== 4'h0) return;
        // Character handshake waits for the device to be ready
        while (!sw[7] && cts !== 1'b1 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        // A stuck handshake sends nothing, so the bench's own wait runs out
        if (k >= 5000) return;
        bit_out(1'b0, t);
        for (int i = 0; i < 8; i++) bit_out(c[i], t);
        if (sw[3]) bit_out(sw[4] ? ^c : ~^c, t);
        bit_out(1'b1, (sw[5] && sw[6]) ? 2 * t : (sw[6] ? t + t / 2 : t));
    endtask
endmodule
`default_nettype wire

// File: tb/scfc_channel_tb.sv
// Purpose: Self-checking bench for the serial channel block
// Assumes: Short CLK_HZ so one bit lasts 8 to 533 clocks
// Notes: Settings model held as ints; line sampled mid-bit
`timescale 1ns/1ps
`default_nettype none
`include "scfc_params.svh"
module scfc_channel_tb;
    localparam int CLK_HZ = 160000;
    logic clk, sys_rst, ce, set_channel_command, op_flow, op_long8, op_stop2;
    logic [4:0] cmd_present;
    logic [2:0] op_baud, answer_value, prompt_field, prompt_value, cfg_baud;
    logic [1:0] parity_operand, cfg_parity;
    logic answer_valid, answer_keep, prompt_valid, cfg_flow, cfg_long8, cfg_stop2;
    logic tx_valid, tx_ready, rx_valid, rx_parity_err, rx_frame_err, rx_ack;
    logic [7:0] tx_data, rx_data, sw;
    logic ser_out, ser_in, rts_in, cts_out, dsr_out, dcd_out, busy;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 89639;
    int mv [5];
    int rate [7] = '{19200, 9600, 4800, 2400, 1200, 600, 300};
    int lim [5] = '{2, 7, 2, 3, 2};

    scfc_channel #(.CLK_HZ(CLK_HZ)) dut_u (
        .clk, .sys_rst, .ce, .set_channel_command, .cmd_present, .op_flow, .op_baud,
        .op_long8, .parity_operand, .op_stop2, .prompt_valid, .prompt_field,
        .prompt_value, .answer_valid, .answer_keep, .answer_value, .cfg_flow,
        .cfg_baud, .cfg_long8, .cfg_parity, .cfg_stop2, .tx_valid, .tx_data,
        .tx_ready, .rx_valid, .rx_data, .rx_parity_err, .rx_frame_err, .rx_ack,
        .ser_out, .ser_in, .rts_in, .cts_out, .dsr_out, .dcd_out
    );
    scfc_partner #(.CLK_HZ(CLK_HZ)) p_u (
        .clk, .sw, .insp(4'h0), .busy, .cts(cts_out), .ser(ser_in), .rts(rts_in)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic summarize();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic give_up();
        n_errors++;
        summarize();
    endtask
    task automatic chk8(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chk1(input string nm, input logic seen, input logic exp);
        chk8(nm, {7'h0, seen}, {7'h0, exp});
    endtask
    task automatic chk_cfg();
        chk1("cfg_flow", cfg_flow, mv[0][0]);
        chk8("cfg_baud", 8'(cfg_baud), 8'(mv[1]));
        chk1("cfg_long8", cfg_long8, mv[2][0]);
        chk8("cfg_parity", 8'(cfg_parity), 8'(mv[3]));
        chk1("cfg_stop2", cfg_stop2, mv[4][0]);
    endtask
    task automatic cmd(input logic [4:0] pres, input int f, b, l, p, s);
        int v [5];
        v = '{f, b, l, p, s};
        @(negedge clk);
        set_channel_command = 1'b1;
        cmd_present = pres;
        op_flow = f[0];
        op_baud = b[2:0];
        op_long8 = l[0];
        parity_operand = p[1:0];
        op_stop2 = s[0];
        @(negedge clk);
        set_channel_command = 1'b0;
        for (int i = 0; i < 5; i++) if (pres[i]) mv[i] = v[i];
    endtask
    function automatic logic [7:0] to_sw();
        return {mv[0][0], mv[4][0], 1'b1, mv[3] == 1, mv[3] != 0, 3'(7 - mv[1])};
    endfunction
    task automatic tx_char(input logic [7:0] c);
        int d = CLK_HZ / rate[mv[1]];
        int k = 0;
        logic pb = 1'b0;
        logic b [$];
        b.push_back(1'b0);
        for (int i = 0; i < 7 + mv[2]; i++) begin
            b.push_back(c[i]);
            pb = pb ^ c[i];
        end
        if (mv[3] == 1) b.push_back(pb);
        if (mv[3] == 2) b.push_back(!pb);
        b.push_back(1'b1);
        if (mv[4] == 1) b.push_back(1'b1);
        @(negedge clk);
        tx_valid = 1'b1;
        tx_data = c;
        while (tx_ready !== 1'b1) begin
            if (++k > 5000) give_up();
            @(negedge clk);
        end
        @(negedge clk);
        tx_valid = 1'b0;
        repeat (d / 2) @(negedge clk);
        foreach (b[i]) begin
            chk1("ser_out", ser_out, b[i]);
            repeat (d) @(negedge clk);
        end
    endtask
    task automatic rx_char(input logic [7:0] c, input logic perr);
        int k = 0;
        p_u.send(c);
        while (rx_valid !== 1'b1) begin
            if (++k > 200) give_up();
            @(negedge clk);
        end
        chk8("rx_data", rx_data, c);
        chk1("rx_parity_err", rx_parity_err, perr);
        chk1("rx_frame_err", rx_frame_err, 1'b0);
        chk1("cts_out", cts_out, mv[0] == 1);
        rx_ack = 1'b1;
        @(negedge clk);
        rx_ack = 1'b0;
        @(negedge clk);
        chk1("rx_valid", rx_valid, 1'b0);
        chk1("cts_out", cts_out, 1'b1);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        give_up();
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        set_channel_command = 1'b0;
        cmd_present = 5'h00;
        op_flow = 1'b0;
        op_baud = 3'h0;
        op_long8 = 1'b0;
        parity_operand = 2'h0;
        op_stop2 = 1'b0;
        answer_valid = 1'b0;
        answer_keep = 1'b0;
        answer_value = 3'h0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ack = 1'b0;
        busy = 1'b0;
        sw = 8'h00;
        mv = '{0, 1, 1, 0, 1};
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        chk_cfg();
        chk1("ser_out", ser_out, 1'b1);
        chk1("dsr_out", dsr_out, 1'b1);
        chk1("dcd_out", dcd_out, 1'b1);
        // Every baud code through operands; mode, length, parity and stop operands present at random
        for (int i = 0; i < 7; i++) begin
            cmd(5'($random(seed)) | 5'h02, i % 2, i, $random(seed) & 1, i % 3, i / 4);
            chk_cfg();
        end
        // Interactive walk, with a command offered mid-prompt that must be ignored
        cmd(5'h00, 0, 6, 0, 2, 0);
        for (int f = 0; f < 5; f++) begin
            chk1("prompt_valid", prompt_valid, 1'b1);
            chk8("prompt_field", 8'(prompt_field), 8'(f));
            chk8("prompt_value", 8'(prompt_value), 8'(mv[f]));
            answer_valid = 1'b1;
            answer_keep = f[0];
            answer_value = 3'(($random(seed) & 32'h7fff) % lim[f]);
            if (!answer_keep) mv[f] = answer_value;
            set_channel_command = (f == 2);
            cmd_present = 5'h1f;
            @(negedge clk);
        end
        answer_valid = 1'b0;
        set_channel_command = 1'b0;
        chk1("prompt_valid", prompt_valid, 1'b0);
        chk_cfg();
        // Framing of sent characters at 19200
        for (int i = 0; i < 6; i++) begin
            cmd(5'h1f, 0, 0, i % 2, i % 3, i / 3);
            tx_char(8'($random(seed)));
        end
        // Received characters from the programmer, matched switch settings
        for (int i = 1; i < 4; i++) begin
            cmd(5'h1f, 0, i, 1, i - 1, i % 2);
            sw = to_sw();
            rx_char(8'($random(seed)), 1'b0);
        end
        // Far end set to the other parity: the character is flagged
        cmd(5'h1f, 0, 1, 1, 1, 1);
        sw = to_sw() ^ 8'h10;
        rx_char(8'($random(seed)), 1'b1);
        busy = 1'b1;
        @(negedge clk);
        chk1("tx_ready", tx_ready, 1'b0);
        busy = 1'b0;
        @(negedge clk);
        chk1("tx_ready", tx_ready, 1'b1);
        // Software flow: pause on the stop code, resume on the start code
        cmd(5'h1f, 1, 1, 1, 0, 1);
        sw = to_sw();
        busy = 1'b1;
        rx_char(`SCFC_XOFF, 1'b0);
        chk1("tx_ready", tx_ready, 1'b0);
        rx_char(`SCFC_XON, 1'b0);
        chk1("tx_ready", tx_ready, 1'b1);
        tx_char(8'($random(seed)));
        // A held enable freezes a command
        ce = 1'b0;
        set_channel_command = 1'b1;
        cmd_present = 5'h02;
        op_baud = 3'h6;
        @(negedge clk);
        set_channel_command = 1'b0;
        ce = 1'b1;
        chk_cfg();
        // Reset in mid-run restores the defaults
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        mv = '{0, 1, 1, 0, 1};
        chk_cfg();
        summarize();
    end
endmodule
`default_nettype wire
